//--- design/snvc_core.sv
module snvc_core
    import snvc_pkg::*;
#(
    parameter int AW = ADDR_W
)(
    // system clock and power-up reset
    input wire logic clk,
    input wire logic arst_n,
    // serial link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic wp_n,
    // system-side observation
    output logic latch_state,
    output logic array_written,
    output logic status_written
);

    // ==========================================================
    // guard decode
    function automatic logic in_guard(input logic [1:0] bp, input logic [AW-1:0] a);
        case (bp)
            2'b00: in_guard = 1'b0;
            2'b01: in_guard = (a >= GUARD_QUARTER_BASE);
            2'b10: in_guard = (a >= GUARD_HALF_BASE);
            default: in_guard = (a >= GUARD_ALL_BASE);
        endcase
    endfunction

    // ==========================================================
    // link-side storage and state
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] status_q;
    logic wel_q;
    snvc_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [AW-1:0] addr_q;
    logic is_read_q;
    logic [2:0] wp_s_q;
    logic wp_n_q;
    logic arr_tgl_q;
    logic st_tgl_q;
    logic so_q;
    logic sel_rst_n;
    logic [7:0] sh_d;
    logic op_done;
    logic addr_done;
    logic byte_done;
    logic arr_wr;
    logic st_wr;
    logic [7:0] status_rd;
    logic [7:0] tx_byte;

    // session reset: chip select high discards any partial transfer
    assign sel_rst_n = arst_n & ~cs_n;

    assign sh_d = {sh_q[6:0], si};
    assign op_done = (state_q == SNVC_OPCODE) && (cnt_q == OP_LAST_BIT);
    assign addr_done = (state_q == SNVC_ADDR) && (cnt_q == ADDR_LAST_BIT);
    assign byte_done = (cnt_q[2:0] == BYTE_LAST_BIT);

    // latch clear refuses every write
    assign arr_wr = (state_q == SNVC_WDATA) && byte_done && wel_q
                    && !in_guard({status_q[ST_BLOCK_HI_BIT], status_q[ST_BLOCK_LO_BIT]},
                                 addr_q);
    assign st_wr = (state_q == SNVC_WSTAT) && byte_done && wel_q
                   && !(status_q[ST_GUARD_EN_BIT] && !wp_n_q);

    always_comb
    begin
        status_rd = status_q & ST_WRITABLE_MASK;
        status_rd[ST_LATCH_BIT] = wel_q;
    end

    // ==========================================================
    // protect pin synchroniser on the link clock
    always_ff @(posedge sck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wp_s_q <= 3'h0;
            wp_n_q <= 1'b0;
        end
        else
        begin
            wp_s_q <= {wp_s_q[1:0], wp_n};
            if (wp_s_q[1] == wp_s_q[2])
            begin
                wp_n_q <= wp_s_q[2];
            end
        end
    end

    // ==========================================================
    // command sequencer, input sampled on rising edge
    always_ff @(posedge sck or negedge sel_rst_n)
    begin
        if (!sel_rst_n)
        begin
            state_q <= SNVC_OPCODE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            is_read_q <= 1'b0;
        end
        else
        begin
            sh_q <= sh_d;
            cnt_q <= cnt_q + 4'h1;
            case (state_q)
                SNVC_OPCODE:
                begin
                    if (op_done)
                    begin
                        cnt_q <= 4'h0;
                        is_read_q <= (sh_d == OP_READ_ARRAY);
                        case (sh_d)
                            OP_READ_STATUS: state_q <= SNVC_RSTAT;
                            OP_WRITE_STATUS: state_q <= SNVC_WSTAT;
                            OP_READ_ARRAY: state_q <= SNVC_ADDR;
                            OP_WRITE_ARRAY: state_q <= SNVC_ADDR;
                            default: state_q <= SNVC_DONE;
                        endcase
                    end
                end
                SNVC_ADDR:
                begin
                    if (addr_done)
                    begin
                        cnt_q <= 4'h0;
                        state_q <= is_read_q ? SNVC_RDATA : SNVC_WDATA;
                    end
                end
                SNVC_WDATA, SNVC_RDATA, SNVC_RSTAT:
                begin
                    cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
                end
                SNVC_WSTAT:
                begin
                    if (byte_done)
                    begin
                        state_q <= SNVC_DONE;
                    end
                end
                SNVC_DONE:
                begin
                    cnt_q <= 4'h0;
                end
                default:
                begin
                    state_q <= SNVC_DONE;
                end
            endcase
        end
    end

    // ==========================================================
    // address shift and auto increment, top address bit falls off
    always_ff @(posedge sck or negedge sel_rst_n)
    begin
        if (!sel_rst_n)
        begin
            addr_q <= '0;
        end
        else if (state_q == SNVC_ADDR)
        begin
            addr_q <= {addr_q[AW-2:0], si};
        end
        else if ((state_q == SNVC_RDATA || state_q == SNVC_WDATA) && byte_done)
        begin
            addr_q <= addr_q + 1'b1;
        end
    end

    // ==========================================================
    // write enable latch
    always_ff @(posedge sck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wel_q <= 1'b0;
        end
        else if (!cs_n && op_done)
        begin
            if (sh_d == OP_SET_WRITE_LATCH)
            begin
                wel_q <= 1'b1;
            end
            else if (sh_d == OP_CLEAR_WRITE_LATCH)
            begin
                wel_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // nonvolatile status bits; latch kept after status write
    always_ff @(posedge sck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_q <= ST_RESET;
            st_tgl_q <= 1'b0;
        end
        else if (!cs_n && st_wr)
        begin
            status_q <= sh_d & ST_WRITABLE_MASK;
            st_tgl_q <= ~st_tgl_q;
        end
    end

    // ==========================================================
    // memory array
    always_ff @(posedge sck)
    begin
        if (!cs_n && arst_n && arr_wr)
        begin
            mem[addr_q] <= sh_d;
        end
    end

    always_ff @(posedge sck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arr_tgl_q <= 1'b0;
        end
        else if (!cs_n && arr_wr)
        begin
            arr_tgl_q <= ~arr_tgl_q;
        end
    end

    // ==========================================================
    // serial output, changed on falling edge
    assign tx_byte = (state_q == SNVC_RSTAT) ? status_rd : mem[addr_q];

    always_ff @(negedge sck or negedge sel_rst_n)
    begin
        if (!sel_rst_n)
        begin
            so_q <= 1'b0;
        end
        else if (state_q == SNVC_RSTAT || state_q == SNVC_RDATA)
        begin
            so_q <= tx_byte[~cnt_q[2:0]];
        end
        else
        begin
            so_q <= 1'b0;
        end
    end

    assign so = so_q;
    assign so_oe = sel_rst_n;

    // ==========================================================
    // crossing to the system clock
    logic [2:0] sync_q [0:2];
    logic [2:0] seen_q;
    logic [2:0] src_bits;

    assign src_bits = {wel_q, st_tgl_q, arr_tgl_q};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    sync_q[g] <= 3'h0;
                    seen_q[g] <= 1'b0;
                end
                else
                begin
                    sync_q[g] <= {sync_q[g][1:0], src_bits[g]};
                    if (sync_q[g][1] == sync_q[g][2])
                    begin
                        seen_q[g] <= sync_q[g][2];
                    end
                end
            end
        end
    endgenerate

    logic arr_pulse_q;
    logic st_pulse_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arr_pulse_q <= 1'b0;
            st_pulse_q <= 1'b0;
        end
        else
        begin
            arr_pulse_q <= (sync_q[0][1] == sync_q[0][2]) && (sync_q[0][2] != seen_q[0]);
            st_pulse_q <= (sync_q[1][1] == sync_q[1][2]) && (sync_q[1][2] != seen_q[1]);
        end
    end

    assign latch_state = seen_q[2];
    assign array_written = arr_pulse_q;
    assign status_written = st_pulse_q;

endmodule // snvc_core

//--- design/snvc_pkg.sv
package snvc_pkg;

    // ==========================================================
    // op-codes
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_ARRAY = 8'h03;
    localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;

    // ==========================================================
    // status register layout
    localparam int ST_GUARD_EN_BIT = 7;
    localparam int ST_BLOCK_HI_BIT = 3;
    localparam int ST_BLOCK_LO_BIT = 2;
    localparam int ST_LATCH_BIT = 1;
    localparam logic [7:0] ST_WRITABLE_MASK = 8'hfc;
    localparam logic [7:0] ST_RESET = 8'h00;

    // ==========================================================
    // array geometry and guard bases
    localparam int ADDR_W = 15;
    localparam logic [14:0] GUARD_QUARTER_BASE = 15'h6000;
    localparam logic [14:0] GUARD_HALF_BASE = 15'h4000;
    localparam logic [14:0] GUARD_ALL_BASE = 15'h0000;

    // ==========================================================
    // bit counts per phase
    localparam logic [3:0] OP_LAST_BIT = 4'h7;
    localparam logic [3:0] ADDR_LAST_BIT = 4'hf;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        SNVC_OPCODE,
        SNVC_ADDR,
        SNVC_WDATA,
        SNVC_RDATA,
        SNVC_RSTAT,
        SNVC_WSTAT,
        SNVC_DONE
    } snvc_state_e;

endpackage

//--- verif/snvc_core_assertions.sv
module snvc_core_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic so,
    input wire logic so_oe,
    // observation
    input wire logic latch_state,
    input wire logic array_written,
    input wire logic status_written
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ====================
    // checks
    chk_oe_when_selected: assert property (!cs_n |-> so_oe)
        else $error("output not enabled while selected");
    chk_float_when_idle: assert property (cs_n |-> !so_oe && !so)
        else $error("output active while deselected");
    chk_so_on_fall: assert property ($changed(so) |-> $fell(sck) || $rose(cs_n))
        else $error("serial output moved off a falling edge");
    chk_array_one_pulse: assert property (array_written |=> !array_written)
        else $error("array write pulse too long");
    chk_status_one_pulse: assert property (status_written |=> !status_written)
        else $error("status write pulse too long");
    chk_array_needs_latch: assert property (array_written |-> latch_state)
        else $error("array write with latch clear");
    chk_status_needs_latch: assert property (status_written |-> latch_state)
        else $error("status write with latch clear");
    chk_latch_kept: assert property (status_written |=> latch_state [*8])
        else $error("latch dropped after status write");
    cover property (array_written);
    cover property (status_written);
    cover property ($fell(latch_state));
endmodule // snvc_core_assertions

bind snvc_core snvc_core_assertions u_chk (.clk, .arst_n, .sck, .cs_n, .so, .so_oe,
    .latch_state, .array_written, .status_written);

//--- verif/snvc_host.sv
module snvc_host (
    // serial link
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_byte;
    event rx_ev;
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end
    // ====================
    // mode 0 framing, sck stands low outside frames
    task automatic start();
        #3 cs_n = 1'b0;
        #15;
    endtask
    task automatic stop();
        cs_n = 1'b1;
        si = ~si;
        #30;
    endtask
    // n bits msb first; a floating output reads as the inverse of the previous bit
    task automatic xfer(input logic [7:0] tx, input int n, input bit capt);
        logic [7:0] rx;
        rx = '0;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            #15 rx = {rx[6:0], so_oe ? so : ~rx[0]};
            sck = 1'b1;
            #15 sck = 1'b0;
        end
        rx_byte = rx;
        if (capt)
            -> rx_ev;
    endtask
endmodule // snvc_host

//--- verif/test_snvc_core.sv
module test_snvc_core
    import snvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, wp_n, sck, cs_n, si, so, so_oe;
    logic latch_state, array_written, status_written, write_enable_latch;
    logic [1:0] bp;
    logic [7:0] r;
    logic [7:0] d[3];
    logic [7:0] q_rd[$];
    logic [1:0] q_ev[$];
    int miscompares, checks;

    snvc_core dut (.clk, .arst_n, .sck, .cs_n, .si, .so, .so_oe, .wp_n,
        .latch_state, .array_written, .status_written);
    snvc_host host (.sck, .cs_n, .si, .so, .so_oe);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ====================
    // checking
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected byte t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_evt(input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected write t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(host.rx_ev)
        cmp_byte(q_rd.size() ? q_rd.pop_front() : 8'hxx, host.rx_byte);
    always @(negedge clk)
        if (array_written === 1'b1 || status_written === 1'b1)
            cmp_evt(q_ev.size() ? q_ev.pop_front() : 2'bxx, {status_written, array_written});
    // ====================
    // commands
    function automatic bit blocked(input logic [14:0] x);
        return !write_enable_latch || bp == 2'h3 || (bp == 2'h2 && x >= GUARD_HALF_BASE)
            || (bp == 2'h1 && x >= GUARD_QUARTER_BASE);
    endfunction
    task automatic cmd(input logic [7:0] op);
        if (op == OP_SET_WRITE_LATCH)
            write_enable_latch = 1'b1;
        if (op == OP_CLEAR_WRITE_LATCH)
            write_enable_latch = 1'b0;
        host.start();
        host.xfer(op, 8, 1'b0);
        host.stop();
    endtask
    task automatic rd_status(input logic [7:0] e, input int n);
        host.start();
        host.xfer(OP_READ_STATUS, 8, 1'b0);
        repeat (n)
        begin
            q_rd.push_back(e);
            host.xfer(8'($urandom), 8, 1'b1);
        end
        host.stop();
    endtask
    task automatic wr_status(input logic [7:0] v, input bit ok);
        cmd(OP_SET_WRITE_LATCH);
        host.start();
        host.xfer(OP_WRITE_STATUS, 8, 1'b0);
        if (ok)
            q_ev.push_back(2'b10);
        host.xfer(v, 8, 1'b0);
        host.stop();
    endtask
    task automatic mem(input logic [7:0] op, input logic [15:0] a, input int n);
        host.start();
        host.xfer(op, 8, 1'b0);
        host.xfer(a[15:8], 8, 1'b0);
        host.xfer(a[7:0], 8, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            if (op == OP_READ_ARRAY)
                q_rd.push_back(d[i]);
            else if (!blocked(a[14:0] + 15'(i)))
                q_ev.push_back(2'b01);
            host.xfer(op == OP_READ_ARRAY ? 8'($urandom) : d[i], 8, op == OP_READ_ARRAY);
        end
        host.stop();
    endtask
    // ====================
    // main sequence
    initial
    begin
        r = $urandom(32'hc0ef392f);
        {miscompares, checks} = '0;
        {wp_n, arst_n, write_enable_latch, bp} = 5'h10;
        repeat (8) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        rd_status(8'h00, 1);
        cmd(OP_SET_WRITE_LATCH);
        repeat (2) @(negedge clk);
        cmp_byte(8'h01, {7'h0, latch_state});
        rd_status(8'h02, 2);
        wr_status(r & 8'hf3, 1'b1);
        rd_status((r & 8'hf0) | 8'h02, 1);
        d[0] = 8'($urandom);
        cmd(OP_SET_WRITE_LATCH);
        mem(OP_WRITE_ARRAY, 16'h6000, 1);
        cmd(OP_CLEAR_WRITE_LATCH);
        r = d[0];
        d[0] = ~r;
        mem(OP_WRITE_ARRAY, 16'h6000, 1);
        cmp_byte(8'h00, {7'h0, latch_state});
        d[0] = r;
        mem(OP_READ_ARRAY, 16'he000, 1);
        d = '{8'($urandom), 8'($urandom), 8'($urandom)};
        cmd(OP_SET_WRITE_LATCH);
        mem(OP_WRITE_ARRAY, 16'hfffe, 3);
        mem(OP_READ_ARRAY, 16'h7ffe, 3);
        for (int g = 0; g < 4; g++)
        begin
            bp = 2'(g);
            wr_status(8'(g << 2), 1'b1);
            mem(OP_WRITE_ARRAY, 16'h3fff, 2);
            cmd(OP_SET_WRITE_LATCH);
            mem(OP_WRITE_ARRAY, 16'h5fff, 2);
        end
        wr_status(8'h80, 1'b1);
        @(negedge clk) wp_n = 1'b0;
        wr_status(8'h0c, 1'b0);
        rd_status(8'h82, 1);
        @(negedge clk) wp_n = 1'b1;
        cmd(OP_CLEAR_WRITE_LATCH);
        host.start();
        host.xfer(OP_SET_WRITE_LATCH, 7, 1'b0);
        host.stop();
        rd_status(8'h80, 1);
        // status write with the latch clear must leave the status untouched
        host.start();
        host.xfer(OP_WRITE_STATUS, 8, 1'b0);
        host.xfer(8'h0c, 8, 1'b0);
        host.stop();
        rd_status(8'h80, 1);
        for (int i = 0; i < 100 && (q_rd.size() || q_ev.size()); i++)
            @(negedge clk);
        if (q_rd.size() || q_ev.size())
            miscompares++;
        complete_run();
    end
    initial
    begin
        #500us;
        miscompares++;
        complete_run();
    end
endmodule // test_snvc_core
